// ### core/acipm_defines.vh
// Register map, field positions and constants for the ADC input control block
`ifndef ACIPM_DEFINES_VH
`define ACIPM_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ACIPM_ADDR_ADC_CTRL 4'h0
`define ACIPM_ADDR_IN_CTRL 4'h4
`define ACIPM_ADDR_PEAK 4'h8
`define ACIPM_ADDR_SAMPLE 4'hC
`define ACIPM_ADDR_W 4

// ****************************************
// Field positions
// ****************************************
`define ACIPM_SEL_LSB 0
`define ACIPM_SEL_MSB 1
`define ACIPM_MUTE_R_BIT 2
`define ACIPM_MUTE_L_BIT 3
`define ACIPM_MUTE_M_BIT 4
`define ACIPM_GAIN_R_LSB 0
`define ACIPM_GAIN_R_MSB 1
`define ACIPM_GAIN_L_LSB 2
`define ACIPM_GAIN_L_MSB 3
`define ACIPM_SAMPLE_VALID_BIT 31

// ****************************************
// Values
// ****************************************
`define ACIPM_SEL_DIFF 2'h3
`define ACIPM_SEL_RESET 2'h0
`define ACIPM_GAIN_RESET 2'h0
`define ACIPM_MUTE_RESET 1'b0
`define ACIPM_RESP_OKAY 2'h0
`define ACIPM_RESP_SLVERR 2'h2
`define ACIPM_HPF_SHIFT 11
`define ACIPM_HPF_FRAC 12
`define ACIPM_PEAK_W 8
`define ACIPM_CH_L 2'h0
`define ACIPM_CH_R 2'h1
`define ACIPM_CH_M 2'h2

`endif

// ### core/acipm_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module acipm_fifo #(
  parameter WIDTH = 22,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ### core/acipm_top.v
// ADC input selection, mute, gain, DC-blocking filter and peak monitor with AXI4-Lite registers
// How it works
// [RULE_01] Two-bit select field routes one of three stereo input pairs to the ADC.
// [RULE_02] Select value 3 switches the stereo ADC inputs to differential pairs.
// [RULE_03] Three independent mute bits silence right, left and mono ADCs.
// [RULE_04] Separate two-bit left and right gains give 0 to 9 dB in 3 dB steps.
// [RULE_05] A new gain setting reaches the pins on the register write itself.
// [RULE_06] Host should mute a channel before changing its gain.
// [RULE_07] Per channel, the status register holds the largest output level since last read.
// [RULE_08] Reading the peak status clears it to zero; tracking restarts from zero.
// [RULE_09] Decimated samples pass a first-order high-pass filter removing DC.
// [RULE_10] Corner is 3.4 Hz at 44.1 kHz, no ripple, scaling with sample rate.
// [RULE_11] Peak compares two's-complement sample magnitude and keeps the larger.
`timescale 1ns/1ps
`include "acipm_defines.vh"
module acipm_top #(
  parameter SAMPLE_W = 20,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire dec_valid,
  output reg dec_ready,
  input wire [SAMPLE_W-1:0] dec_left,
  input wire [SAMPLE_W-1:0] dec_right,
  input wire [SAMPLE_W-1:0] dec_mono,
  output reg [1:0] input_pair_select,
  output reg differential_mode,
  output reg right_adc_mute,
  output reg left_adc_mute,
  output reg mono_adc_mute,
  output reg [1:0] right_input_gain,
  output reg [1:0] left_input_gain
);
  localparam FW = SAMPLE_W + 2;
  localparam YW = SAMPLE_W + `ACIPM_HPF_FRAC + 2;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CALC = 2'h1;
  localparam [1:0] ST_PUSH = 2'h2;

  // ****************************************
  // Helpers
  // ****************************************
  function [SAMPLE_W-2:0] mag_of;
    input [SAMPLE_W-1:0] s;
    reg [SAMPLE_W-1:0] n;
    begin
      n = ~s + 1'b1;
      if (!s[SAMPLE_W-1]) begin
        mag_of = s[SAMPLE_W-2:0];
      end else if (n[SAMPLE_W-1]) begin
        mag_of = {(SAMPLE_W-1){1'b1}};
      end else begin
        mag_of = n[SAMPLE_W-2:0];
      end
    end
  endfunction

  function [`ACIPM_PEAK_W-1:0] peak_next;
    input [`ACIPM_PEAK_W-1:0] held;
    input [`ACIPM_PEAK_W-1:0] lvl;
    begin
      peak_next = (lvl > held) ? lvl : held;
    end
  endfunction

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  reg [`ACIPM_ADDR_W-1:0] waddr_q;
  reg have_aw_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg have_w_q;
  wire do_write;
  wire [1:0] sel_wr;

  assign do_write = have_aw_q & have_w_q & ~s_axi_bvalid;
  assign sel_wr = wdata_q[`ACIPM_SEL_MSB:`ACIPM_SEL_LSB];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACIPM_RESP_OKAY;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      waddr_q <= {`ACIPM_ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      input_pair_select <= `ACIPM_SEL_RESET;
      differential_mode <= 1'b0;
      right_adc_mute <= `ACIPM_MUTE_RESET;
      left_adc_mute <= `ACIPM_MUTE_RESET;
      mono_adc_mute <= `ACIPM_MUTE_RESET;
      right_input_gain <= `ACIPM_GAIN_RESET;
      left_input_gain <= `ACIPM_GAIN_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_q <= s_axi_awaddr[`ACIPM_ADDR_W-1:0];
        have_aw_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        have_w_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ACIPM_RESP_OKAY;
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        case (waddr_q)
          `ACIPM_ADDR_ADC_CTRL: begin
            if (wstrb_q[0]) begin
              input_pair_select <= sel_wr; // [RULE_01]
              differential_mode <= (sel_wr == `ACIPM_SEL_DIFF); // [RULE_02]
              right_adc_mute <= wdata_q[`ACIPM_MUTE_R_BIT]; // [RULE_03]
              left_adc_mute <= wdata_q[`ACIPM_MUTE_L_BIT]; // [RULE_03]
              mono_adc_mute <= wdata_q[`ACIPM_MUTE_M_BIT]; // [RULE_03]
            end
          end
          `ACIPM_ADDR_IN_CTRL: begin
            if (wstrb_q[0]) begin
              // Pins follow at once, no zero-crossing wait [RULE_05]
              right_input_gain <= wdata_q[`ACIPM_GAIN_R_MSB:`ACIPM_GAIN_R_LSB]; // [RULE_04]
              left_input_gain <= wdata_q[`ACIPM_GAIN_L_MSB:`ACIPM_GAIN_L_LSB]; // [RULE_04]
            end
          end
          `ACIPM_ADDR_PEAK, `ACIPM_ADDR_SAMPLE: begin
            s_axi_bresp <= `ACIPM_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `ACIPM_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Sample path: high-pass filter, mute, FIFO
  // ****************************************
  reg [1:0] state_q;
  reg [1:0] ch_q;
  reg [SAMPLE_W-1:0] cap_q [0:2];
  reg [SAMPLE_W-1:0] hp_x_q [0:2];
  reg signed [YW-1:0] hp_y_q [0:2];
  reg [SAMPLE_W-1:0] out_q;
  reg out_new_q;
  reg chan_mute;
  reg signed [YW-1:0] x_now;
  reg signed [YW-1:0] x_old;
  reg signed [YW-1:0] y_nxt;
  reg signed [YW-1:0] y_rnd;
  reg [SAMPLE_W-1:0] y_sat;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire fifo_pop;
  wire fifo_push;
  integer i;

  assign fifo_push = (state_q == ST_PUSH);

  always @* begin
    case (ch_q)
      `ACIPM_CH_L: chan_mute = left_adc_mute;
      `ACIPM_CH_R: chan_mute = right_adc_mute;
      default: chan_mute = mono_adc_mute;
    endcase
    x_now = $signed({{2{cap_q[ch_q][SAMPLE_W-1]}}, cap_q[ch_q], {`ACIPM_HPF_FRAC{1'b0}}});
    x_old = $signed({{2{hp_x_q[ch_q][SAMPLE_W-1]}}, hp_x_q[ch_q], {`ACIPM_HPF_FRAC{1'b0}}});
    // y = x - x_prev + (1 - 2^-11) y_prev: pole set relative to Fs [RULE_09] [RULE_10]
    y_nxt = x_now - x_old + hp_y_q[ch_q] - (hp_y_q[ch_q] >>> `ACIPM_HPF_SHIFT);
    y_rnd = y_nxt >>> `ACIPM_HPF_FRAC;
    if (y_rnd > $signed({3'b000, {(SAMPLE_W-1){1'b1}}, {(YW-SAMPLE_W-2){1'b0}}}) >>> (YW-SAMPLE_W-2)) begin
      y_sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else if (y_rnd < -($signed({3'b000, {(SAMPLE_W-1){1'b1}}}) + 1)) begin
      y_sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      y_sat = y_rnd[SAMPLE_W-1:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      ch_q <= `ACIPM_CH_L;
      dec_ready <= 1'b0;
      out_q <= {SAMPLE_W{1'b0}};
      out_new_q <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        cap_q[i] <= {SAMPLE_W{1'b0}};
        hp_x_q[i] <= {SAMPLE_W{1'b0}};
        hp_y_q[i] <= {YW{1'b0}};
      end
    end else begin
      out_new_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          dec_ready <= 1'b1;
          if (dec_valid && dec_ready) begin
            cap_q[0] <= dec_left;
            cap_q[1] <= dec_right;
            cap_q[2] <= dec_mono;
            dec_ready <= 1'b0;
            ch_q <= `ACIPM_CH_L;
            state_q <= ST_CALC;
          end
        end
        ST_CALC: begin
          hp_x_q[ch_q] <= x_now[SAMPLE_W+`ACIPM_HPF_FRAC-1:`ACIPM_HPF_FRAC]; // [RULE_09]
          hp_y_q[ch_q] <= y_nxt; // [RULE_09]
          out_q <= chan_mute ? {SAMPLE_W{1'b0}} : y_sat; // [RULE_03]
          out_new_q <= 1'b1;
          state_q <= ST_PUSH;
        end
        ST_PUSH: begin
          // Full FIFO stalls here, which holds dec_ready low upstream
          if (fifo_in_ready) begin
            if (ch_q == `ACIPM_CH_M) begin
              state_q <= ST_IDLE;
            end else begin
              ch_q <= ch_q + 2'h1;
              state_q <= ST_CALC;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  acipm_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({ch_q, out_q}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // Peak monitor and AXI4-Lite read path
  // ****************************************
  reg [`ACIPM_PEAK_W-1:0] peak_q [0:2];
  wire [SAMPLE_W-2:0] out_mag;
  wire [`ACIPM_PEAK_W-1:0] out_lvl;
  wire rd_take;
  wire rd_peak;
  wire [`ACIPM_ADDR_W-1:0] raddr;

  assign raddr = s_axi_araddr[`ACIPM_ADDR_W-1:0];
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_peak = rd_take & (raddr == `ACIPM_ADDR_PEAK);
  assign fifo_pop = rd_take & (raddr == `ACIPM_ADDR_SAMPLE) & fifo_out_valid;
  assign out_mag = mag_of(out_q); // [RULE_11]
  assign out_lvl = out_mag[SAMPLE_W-2:SAMPLE_W-1-`ACIPM_PEAK_W];

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 3; i = i + 1) begin
        peak_q[i] <= {`ACIPM_PEAK_W{1'b0}};
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (out_new_q && ch_q == i[1:0]) begin
          // New level beats a clear in the same cycle [RULE_08]
          peak_q[i] <= peak_next(rd_peak ? {`ACIPM_PEAK_W{1'b0}} : peak_q[i], out_lvl); // [RULE_07] [RULE_11]
        end else if (rd_peak) begin
          peak_q[i] <= {`ACIPM_PEAK_W{1'b0}}; // [RULE_08]
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ACIPM_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ACIPM_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (raddr)
          `ACIPM_ADDR_ADC_CTRL: begin
            s_axi_rdata[`ACIPM_SEL_MSB:`ACIPM_SEL_LSB] <= input_pair_select;
            s_axi_rdata[`ACIPM_MUTE_R_BIT] <= right_adc_mute;
            s_axi_rdata[`ACIPM_MUTE_L_BIT] <= left_adc_mute;
            s_axi_rdata[`ACIPM_MUTE_M_BIT] <= mono_adc_mute;
          end
          `ACIPM_ADDR_IN_CTRL: begin
            s_axi_rdata[`ACIPM_GAIN_R_MSB:`ACIPM_GAIN_R_LSB] <= right_input_gain;
            s_axi_rdata[`ACIPM_GAIN_L_MSB:`ACIPM_GAIN_L_LSB] <= left_input_gain;
          end
          `ACIPM_ADDR_PEAK: begin
            s_axi_rdata[3*`ACIPM_PEAK_W-1:0] <= {peak_q[2], peak_q[1], peak_q[0]}; // [RULE_07]
          end
          `ACIPM_ADDR_SAMPLE: begin
            s_axi_rdata[`ACIPM_SAMPLE_VALID_BIT] <= fifo_out_valid;
            s_axi_rdata[FW-1:0] <= fifo_out_valid ? fifo_out_data : {FW{1'b0}};
          end
          default: begin
            s_axi_rresp <= `ACIPM_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ### tb/acipm_chk.sv
// Concurrent checks on the ADC input control block ports
`timescale 1ns/1ps
module acipm_chk (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire dec_valid,
  input wire dec_ready,
  input wire [1:0] input_pair_select,
  input wire differential_mode,
  input wire right_adc_mute,
  input wire left_adc_mute,
  input wire mono_adc_mute,
  input wire [1:0] right_input_gain,
  input wire [1:0] left_input_gain
);
  // ****************************************
  // Last accepted write
  // ****************************************
  reg [3:0] wa_q;
  reg [4:0] wd_q;
  reg ws_q;
  wire [8:0] ctl = {input_pair_select, mono_adc_mute, left_adc_mute, right_adc_mute, left_input_gain, right_input_gain};
  always @(posedge aclk) begin
    if (!aresetn) begin
      wa_q <= 4'h0;
      wd_q <= 5'h0;
      ws_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr[3:0];
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[4:0];
      if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  sequence s_rd_ans;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  property p_sel;
    s_wr_done ##0 (wa_q == 4'h0 && ws_q) |-> input_pair_select == wd_q[1:0];
  endproperty
  property p_diff;
    differential_mode == (input_pair_select == 2'h3);
  endproperty
  property p_mute;
    s_wr_done ##0 (wa_q == 4'h0 && ws_q) |-> {mono_adc_mute, left_adc_mute, right_adc_mute} == wd_q[4:2];
  endproperty
  property p_gain;
    s_wr_done ##0 (wa_q == 4'h4 && ws_q) |-> {left_input_gain, right_input_gain} == wd_q[3:0];
  endproperty
  property p_hold;
    !$stable(ctl) |-> $rose(s_axi_bvalid);
  endproperty
  property p_bresp;
    s_wr_done |-> s_axi_bresp == ((wa_q[1:0] == 2'h0) ? 2'h0 : 2'h2);
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_rd_ans;
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rerr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  property p_dec;
    dec_valid && dec_ready |=> !dec_ready [*6];
  endproperty
  a_sel: assert property (p_sel) else $error("select pins differ from written field");
  a_diff: assert property (p_diff) else $error("differential flag wrong");
  a_mute: assert property (p_mute) else $error("mute pins differ from written bits");
  a_gain: assert property (p_gain) else $error("gain pins differ from written fields");
  a_hold: assert property (p_hold) else $error("control pins changed outside a write");
  a_bresp: assert property (p_bresp) else $error("write response code wrong");
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  a_bdone: assert property (p_bdone) else $error("write channel not freed");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  a_rerr: assert property (p_rerr) else $error("bad read not refused");
  a_dec: assert property (p_dec) else $error("sample ready came back too soon");
endmodule

// ### tb/acipm_src.sv
// Behavioural decimator model feeding sample sets into the block
`timescale 1ns/1ps
module acipm_src (
  input wire aclk,
  input wire dec_ready,
  output reg dec_valid,
  output reg [19:0] dec_left,
  output reg [19:0] dec_right,
  output reg [19:0] dec_mono
);
  initial begin
    dec_valid = 1'b0;
    dec_left = 20'h0;
    dec_right = 20'h0;
    dec_mono = 20'h0;
  end
  // Idles gap+1 cycles, then holds the set until taken; lines invert once released
  task send(input [19:0] l, input [19:0] r, input [19:0] m, input integer gap);
    integer i;
    begin
      for (i = 0; i <= gap; i = i + 1) @(posedge aclk);
      dec_valid <= 1'b1;
      dec_left <= l;
      dec_right <= r;
      dec_mono <= m;
      @(posedge aclk);
      while (!dec_ready) @(posedge aclk);
      dec_valid <= 1'b0;
      dec_left <= ~l;
      dec_right <= ~r;
      dec_mono <= ~m;
    end
  endtask
endmodule

// ### tb/acipm_top_tb.sv
// Self-checking bench for the ADC input control block
`timescale 1ns/1ps
module acipm_top_tb;
  reg aclk;
  reg aresetn;
  reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dec_valid, dec_ready;
  wire differential_mode, right_adc_mute, left_adc_mute, mono_adc_mute;
  wire [1:0] s_axi_bresp, s_axi_rresp, input_pair_select, right_input_gain, left_input_gain;
  wire [31:0] s_axi_rdata;
  wire [19:0] dec_left, dec_right, dec_mono;
  reg [19:0] l1, l2;
  reg [1:0] r;
  integer fails, n_compared, cyc, n, k;

  acipm_top #(.SAMPLE_W(20)) dut_u (.*);
  acipm_src src_u (.aclk(aclk), .dec_ready(dec_ready), .dec_valid(dec_valid), .dec_left(dec_left),
    .dec_right(dec_right), .dec_mono(dec_mono));

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v, output [1:0] resp);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) resp = s_axi_bresp;
      end while (!s_axi_bvalid);
    end
  endtask
  task rd(input [31:0] a, output [31:0] v, output [1:0] resp);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) v = s_axi_rdata;
        if (s_axi_rvalid) resp = s_axi_rresp;
      end while (!s_axi_rvalid);
    end
  endtask
  task wait_idle;
    begin
      @(posedge aclk);
      for (k = 0; k < 50 && !dec_ready; k = k + 1) @(posedge aclk);
    end
  endtask
  task drain;
    begin
      n = 0;
      d = 32'h8000_0000;
      while (d[31] && n < 60) begin
        rd(32'hC, d, r);
        if (d[31]) begin
          chk("chan", d[21:20], n % 3);
          if (n == 3) l1 = d[19:0];
          if (n == 6) l2 = d[19:0];
          n = n + 1;
        end
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    begin
      rd(32'h0, d, r);
      chk("adc_ctrl", d, 32'h0);
      rd(32'h4, d, r);
      chk("in_ctrl", d, 32'h0);
      chk("pins", {differential_mode, mono_adc_mute, left_adc_mute, right_adc_mute}, 32'h0);
    end
  endtask
  task t_sel;
    for (n = 0; n < 4; n = n + 1) begin
      wr(32'h0, n, r);
      chk("sel", input_pair_select, n);
      chk("diff", differential_mode, n == 3);
      rd(32'h0, d, r);
      chk("sel_rd", d, n);
    end
  endtask
  task t_mute;
    for (n = 0; n < 3; n = n + 1) begin
      wr(32'h0, 32'h4 << n, r);
      chk("mute", {mono_adc_mute, left_adc_mute, right_adc_mute}, 32'h1 << n);
    end
  endtask
  task t_gain;
    begin
      wr(32'h0, 32'hC, r);
      for (n = 0; n < 16; n = n + 1) begin
        wr(32'h4, n, r);
        chk("gain", {left_input_gain, right_input_gain}, n);
      end
    end
  endtask
  task t_bad;
    begin
      wr(32'h2, 32'h1F, r);
      chk("bresp_bad", r, 2'h2);
      rd(32'h6, d, r);
      chk("rresp_bad", r, 2'h2);
      chk("rdata_bad", d, 32'h0);
      wr(32'h8, 32'hFF, r);
      chk("bresp_ro", r, 2'h0);
      rd(32'h0, d, r);
      chk("ctrl_kept", d[4:0], 5'hC);
    end
  endtask
  task t_peak;
    begin
      wr(32'h0, 32'h4, r);
      rd(32'h8, d, r);
      src_u.send(20'h4_0000, 20'h4_0000, 20'h0, 3);
      wait_idle;
      rd(32'h8, d, r);
      chk("pk_l", d[7:0] >= 8'h7F && d[7:0] <= 8'h81, 1);
      chk("pk_r_m", d[23:8], 32'h0);
      rd(32'h8, d, r);
      chk("pk_clr", d, 32'h0);
      src_u.send(20'hC_0000, 20'h0, 20'h0, 1);
      wait_idle;
      rd(32'h8, d, r);
      chk("pk_neg", d[7:0] >= 8'h7F && d[7:0] <= 8'h81, 1);
      wr(32'h0, 32'hC, r);
      rd(32'h8, d, r);
      src_u.send(20'hC_0000, 20'h0, 20'h0, 1);
      wait_idle;
      rd(32'h8, d, r);
      chk("pk_mute_l", d[7:0], 8'h0);
    end
  endtask
  task t_fifo;
    begin
      drain;
      chk("fifo_pre", n, 9);
      chk("mute_smp", l2, 20'h0);
      wr(32'h0, 32'h0, r);
      for (k = 0; k < 11; k = k + 1) src_u.send(20'h4_0000, 20'h1_0000, 20'h0_0100, k % 4);
      fork
        src_u.send(20'h4_0000, 20'h1_0000, 20'h0_0100, 1);
      join_none
      repeat (40) @(posedge aclk);
      chk("full_stall", dec_ready, 0);
      drain;
      chk("fifo_cnt", n, 36);
      chk("hpf_dec", l2 < l1, 1);
      chk("hpf_step", (l1 - l2 >= (l1 >> 11) - 1) && (l1 - l2 <= (l1 >> 11) + 1), 1);
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    fails = 0;
    n_compared = 0;
    cyc = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_sel;
    t_mute;
    t_gain;
    t_bad;
    t_peak;
    t_fifo;
    tally_and_finish;
  end
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
endmodule

bind acipm_top acipm_chk chk_u (.*);
